// ### pmic_config_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the
//          power management configuration register bank.
// Assumes: Included by its bare name from the package and the bank.
// Notes:   Definitions only.
`ifndef PMIC_CONFIG_DEFINES_SVH
`define PMIC_CONFIG_DEFINES_SVH

// Register offsets
`define OFS_POWER_ON_EVENT        8'h00
`define OFS_CHARGER_CONTROL       8'h01
`define OFS_BATTERY_LOW_ALARM     8'h04
`define OFS_REGULATOR_ONE_CONTROL 8'h07

// Field positions
`define REG1_EN_BIT      5
`define EVT_ACK_BIT      4
`define CHG_TERM_MSB     7
`define CHG_TERM_LSB     6
`define CHG_CUR_MSB      5
`define CHG_CUR_LSB      2
`define CHG_EN_BIT       1
`define CHG_EOC_BIT      0

// Reset values and the reserved termination code
`define RST_CHG_TERM     2'h1
`define RST_CHG_EN       1'b1
`define RST_CHG_EOC      1'b1
`define RST_BATT_CODE    5'h0c
`define RST_REG1_CODE    5'h00
`define RST_ALARM_MV     12'hb54
`define RST_IRQ_MV       12'hc1c
`define TERM_RESERVED    2'h3

// Code limits and scaling in millivolts
`define REG1_CODE_MAX    5'h15
`define REG1_BASE_MV     12'h4b0
`define REG1_STEP_MV     12'h064
`define CUR_CODE_MAX     4'h9
`define BATT_CODE_MAX    5'h14
`define BATT_TOP_MV      12'hdac
`define BATT_STEP_MV     12'h032
`define BATT_IRQ_OFS_MV  12'h0c8

// Timing, in milliseconds, clock rate in kHz and timer width in bits
`define CLK_FREQ_KHZ     250000
`define ACK_DEADLINE_MS  128
`define RESET_HOLD_MS    2
`define TIMER_W          26

`endif

// ### pmic_config_pkg.sv
// Purpose: Types shared by the configuration register bank.
// Assumes: The timer field width comes from the defines header.
// Notes:   Whole bank state travels as one packed struct.
`include "pmic_config_defines.svh"

package pmic_config_pkg;

    // Power-up supervision states
    typedef enum logic [2:0] {
        ST_OFF,
        ST_WAIT_ACK,
        ST_ACTIVE,
        ST_RESET_HOLD
    } power_state_t;

    // All state of the bank
    typedef struct packed {
        power_state_t        state;
        logic [`TIMER_W-1:0] timer;
        logic [7:0]          rd_data;
        logic                rd_valid;
        logic                ack;
        logic [3:0]          cause;
        logic [1:0]          term;
        logic [3:0]          cur;
        logic                chg_en;
        logic                eoc;
        logic [4:0]          batt_code;
        logic                reg1_en;
        logic [4:0]          reg1_code;
        logic [11:0]         reg1_mv;
        logic [11:0]         alarm_mv;
        logic [11:0]         irq_mv;
        logic [3:0]          cur_out;
    } bank_state_t;

endpackage

// ### pmic_config_register_bank.sv
// Purpose: Configuration and status register bank of a portable power
//          manager, written by the serial slave engine by register index.
// Assumes: The serial engine hands over one index/data pair per write and
//          one index per read; all inputs synchronous to clk.
// Notes:   Also supervises the power-on acknowledge deadline.
`timescale 1ns/100ps
`include "pmic_config_defines.svh"

module pmic_config_register_bank #(
    parameter int unsigned ACK_DEADLINE_CYCLES = `ACK_DEADLINE_MS * `CLK_FREQ_KHZ,
    parameter int unsigned RESET_HOLD_CYCLES   = `RESET_HOLD_MS * `CLK_FREQ_KHZ,
    parameter logic [3:0]  CUR_FACTORY_DEFAULT = 4'h4
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Register access from the serial slave engine
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    input  wire logic [7:0]  reg_index,
    input  wire logic [7:0]  reg_wr_data,
    output logic      [7:0]  reg_rd_data,
    output logic             reg_rd_valid,
    // Power-up sequencer and wake causes
    input  wire logic        power_on_start,
    input  wire logic        seq_reg1_on,
    input  wire logic        wake_battery_insert,
    input  wire logic        wake_push_button,
    input  wire logic        wake_adapter_supply,
    input  wire logic        wake_bus_supply,
    // Host handshake and supply sense
    input  wire logic        power_ack_pin,
    input  wire logic        ext_supply_present,
    // Power and reset control
    output logic             power_enable,
    output logic             system_reset_output_n,
    // First linear regulator
    output logic             reg1_enable,
    output logic             reg1_shunt_enable,
    output logic      [4:0]  reg1_voltage_code,
    output logic      [11:0] reg1_voltage_mv,
    // Charger
    output logic      [1:0]  chg_term_select,
    output logic      [3:0]  full_rate_charge_current,
    output logic             chg_enable,
    output logic             chg_eoc_select,
    // Battery low alarm
    output logic      [11:0] batt_alarm_mv,
    output logic      [11:0] batt_irq_mv
);

    localparam logic [`TIMER_W-1:0] DEADLINE_LAST = `TIMER_W'(ACK_DEADLINE_CYCLES - 1);
    localparam logic [`TIMER_W-1:0] HOLD_LAST     = `TIMER_W'(RESET_HOLD_CYCLES - 1);

    pmic_config_pkg::bank_state_t s_reg;
    pmic_config_pkg::bank_state_t s_next;

    logic       wr_event;
    logic       wr_chg;
    logic       wr_batt;
    logic       wr_reg1;
    logic [3:0] wake_vec;
    logic [4:0] reg1_clamped;
    logic [4:0] batt_clamped;

    // Write decode by register index
    assign wr_event = reg_wr_en && (reg_index == `OFS_POWER_ON_EVENT);
    assign wr_chg   = reg_wr_en && (reg_index == `OFS_CHARGER_CONTROL);
    assign wr_batt  = reg_wr_en && (reg_index == `OFS_BATTERY_LOW_ALARM);
    assign wr_reg1  = reg_wr_en && (reg_index == `OFS_REGULATOR_ONE_CONTROL);
    assign wake_vec = {wake_battery_insert, wake_push_button,
                       wake_adapter_supply, wake_bus_supply};

    // Next state of the whole bank
    always_comb begin
        s_next          = s_reg;
        s_next.rd_valid = 1'b0;
        reg1_clamped    = 5'h00;
        batt_clamped    = 5'h00;

        // Read path; unmapped indices and reserved bits return zero
        if (reg_rd_en) begin
            s_next.rd_valid = 1'b1;
            case (reg_index)
                `OFS_POWER_ON_EVENT:        s_next.rd_data = {3'h0, s_reg.ack, s_reg.cause};
                `OFS_CHARGER_CONTROL:       s_next.rd_data = {s_reg.term, s_reg.cur,
                                                              s_reg.chg_en, s_reg.eoc};
                `OFS_BATTERY_LOW_ALARM:     s_next.rd_data = {3'h0, s_reg.batt_code};
                `OFS_REGULATOR_ONE_CONTROL: s_next.rd_data = {2'h0, s_reg.reg1_en,
                                                              s_reg.reg1_code};
                default:                    s_next.rd_data = 8'h00;
            endcase
        end

        // Acknowledge bit is the only writable bit of the event register
        if (wr_event) begin
            s_next.ack = reg_wr_data[`EVT_ACK_BIT];
        end

        // Charger control; reserved termination code is not stored
        if (wr_chg) begin
            if (reg_wr_data[`CHG_TERM_MSB:`CHG_TERM_LSB] != `TERM_RESERVED) begin
                s_next.term = reg_wr_data[`CHG_TERM_MSB:`CHG_TERM_LSB];
            end
            s_next.cur    = reg_wr_data[`CHG_CUR_MSB:`CHG_CUR_LSB];
            s_next.chg_en = reg_wr_data[`CHG_EN_BIT];
            s_next.eoc    = reg_wr_data[`CHG_EOC_BIT];
        end

        // Battery alarm threshold, upper bits dropped
        if (wr_batt) begin
            s_next.batt_code = reg_wr_data[4:0];
        end

        // Regulator control; voltage taken whatever the enable state
        if (wr_reg1) begin
            s_next.reg1_code = reg_wr_data[4:0];
            s_next.reg1_en   = reg_wr_data[`REG1_EN_BIT];
        end

        // Power-up supervision
        case (s_reg.state)
            pmic_config_pkg::ST_OFF: begin
                s_next.timer = '0;
                if (power_on_start) begin
                    s_next.state = pmic_config_pkg::ST_WAIT_ACK;
                    s_next.cause = 4'h0; // Fresh causes per power-on
                end
            end
            pmic_config_pkg::ST_WAIT_ACK: begin
                if (s_reg.ack || power_ack_pin) begin
                    s_next.state = pmic_config_pkg::ST_ACTIVE;
                    s_next.timer = '0;
                end else if (s_reg.timer == DEADLINE_LAST) begin
                    s_next.state = pmic_config_pkg::ST_RESET_HOLD;
                    s_next.timer = '0;
                end else begin
                    s_next.timer = s_reg.timer + 1'b1;
                end
            end
            pmic_config_pkg::ST_ACTIVE: begin
                s_next.timer = '0;
                if (!s_reg.ack && !power_ack_pin && !ext_supply_present) begin
                    s_next.state = pmic_config_pkg::ST_OFF;
                end
            end
            pmic_config_pkg::ST_RESET_HOLD: begin
                if (s_reg.timer == HOLD_LAST) begin
                    s_next.state = pmic_config_pkg::ST_OFF;
                    s_next.timer = '0;
                end else begin
                    s_next.timer = s_reg.timer + 1'b1;
                end
            end
            default: begin
                s_next.state = pmic_config_pkg::ST_OFF;
                s_next.timer = '0;
            end
        endcase

        // Power removal drops the regulator and the acknowledge
        if ((s_reg.state != pmic_config_pkg::ST_OFF) &&
            (s_next.state == pmic_config_pkg::ST_OFF)) begin
            s_next.reg1_en = 1'b0;
            s_next.ack     = 1'b0;
        end

        // Sequencer enable wins over a software clear
        if (seq_reg1_on) begin
            s_next.reg1_en = 1'b1;
        end

        // Wake causes are sticky; a set wins over the power-on clear
        s_next.cause = s_next.cause | wake_vec;

        // Regulator voltage, clamped at the top setting
        reg1_clamped = (s_next.reg1_code > `REG1_CODE_MAX) ? `REG1_CODE_MAX
                                                           : s_next.reg1_code;
        s_next.reg1_mv = `REG1_BASE_MV + (`REG1_STEP_MV * {7'h00, reg1_clamped});

        // Alarm level with its floor and interrupt offset
        batt_clamped = (s_next.batt_code > `BATT_CODE_MAX) ? `BATT_CODE_MAX
                                                           : s_next.batt_code;
        s_next.alarm_mv = `BATT_TOP_MV - (`BATT_STEP_MV * {7'h00, batt_clamped});
        s_next.irq_mv   = s_next.alarm_mv + `BATT_IRQ_OFS_MV;

        // Charge current codes past the top setting clamp
        s_next.cur_out = (s_next.cur > `CUR_CODE_MAX) ? `CUR_CODE_MAX : s_next.cur;
    end

    // State register with reset values
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg           <= '0;
            s_reg.state     <= pmic_config_pkg::ST_OFF;
            s_reg.term      <= `RST_CHG_TERM;
            s_reg.cur       <= CUR_FACTORY_DEFAULT;
            s_reg.cur_out   <= CUR_FACTORY_DEFAULT;
            s_reg.chg_en    <= `RST_CHG_EN;
            s_reg.eoc       <= `RST_CHG_EOC;
            s_reg.batt_code <= `RST_BATT_CODE;
            s_reg.reg1_code <= `RST_REG1_CODE;
            s_reg.reg1_mv   <= `REG1_BASE_MV;
            s_reg.alarm_mv  <= `RST_ALARM_MV;
            s_reg.irq_mv    <= `RST_IRQ_MV;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign reg_rd_data              = s_reg.rd_data;
    assign reg_rd_valid             = s_reg.rd_valid;
    assign power_enable             = (s_reg.state != pmic_config_pkg::ST_OFF);
    assign system_reset_output_n    = (s_reg.state == pmic_config_pkg::ST_WAIT_ACK) ||
                                      (s_reg.state == pmic_config_pkg::ST_ACTIVE);
    assign reg1_enable              = s_reg.reg1_en;
    assign reg1_shunt_enable        = !s_reg.reg1_en;
    assign reg1_voltage_code        = s_reg.reg1_code;
    assign reg1_voltage_mv          = s_reg.reg1_mv;
    assign chg_term_select          = s_reg.term;
    assign full_rate_charge_current = s_reg.cur_out;
    assign chg_enable               = s_reg.chg_en;
    assign chg_eoc_select           = s_reg.eoc;
    assign batt_alarm_mv            = s_reg.alarm_mv;
    assign batt_irq_mv              = s_reg.irq_mv;

    // Checks on the bank
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_event_read_zero: assert property (
        reg_rd_en && (reg_index == `OFS_POWER_ON_EVENT)
        |=> reg_rd_valid && (reg_rd_data[7:5] == 3'h0))
        else $error("event register read shows reserved bits");

    a_unmapped_read_zero: assert property (
        reg_rd_en && (reg_index != `OFS_POWER_ON_EVENT)
        && (reg_index != `OFS_CHARGER_CONTROL)
        && (reg_index != `OFS_BATTERY_LOW_ALARM)
        && (reg_index != `OFS_REGULATOR_ONE_CONTROL)
        |=> reg_rd_valid && (reg_rd_data == 8'h00))
        else $error("unmapped read not zero");

    a_off_shunts_out: assert property (
        wr_reg1 && !reg_wr_data[`REG1_EN_BIT] && !seq_reg1_on |=> reg1_shunt_enable)
        else $error("disabled regulator not shunted");

    a_live_volt_write: assert property (
        wr_reg1 && reg1_enable && reg_wr_data[`REG1_EN_BIT]
        |=> reg1_enable && (reg1_voltage_code == $past(reg_wr_data[4:0])))
        else $error("voltage write lost while enabled");

    a_volt_range: assert property (
        (reg1_voltage_mv >= 12'h4b0) && (reg1_voltage_mv <= 12'hce4))
        else $error("regulator voltage out of range");

    a_volt_clamp: assert property (
        (reg1_voltage_code >= 5'h15) |-> (reg1_voltage_mv == 12'hce4))
        else $error("regulator code not clamped");

    a_alarm_floor: assert property (
        (s_reg.batt_code >= 5'h14) |-> (batt_alarm_mv == 12'h9c4)
                                       && (batt_irq_mv == 12'ha8c))
        else $error("alarm floor wrong");

    a_seq_enable: assert property (
        seq_reg1_on |=> reg1_enable && !reg1_shunt_enable)
        else $error("sequencer enable not applied");

    a_cause_sticky: assert property (
        wake_push_button |=> s_reg.cause[2] [*2])
        else $error("button cause flag not held");

    a_term_reserved: assert property (
        wr_chg && (reg_wr_data[7:6] == 2'h3) |=> chg_term_select == $past(chg_term_select))
        else $error("reserved termination stored");

    a_reset_first: assert property (
        $fell(system_reset_output_n) && (s_reg.state == pmic_config_pkg::ST_RESET_HOLD)
        |-> power_enable && ($past(s_reg.timer) == DEADLINE_LAST))
        else $error("reset not asserted at deadline with power on");

    a_hold_length: assert property (
        $fell(power_enable) && ($past(s_reg.state) == pmic_config_pkg::ST_RESET_HOLD)
        |-> ($past(s_reg.timer) == HOLD_LAST) && !system_reset_output_n)
        else $error("power removed at wrong time");

endmodule

// ### pmic_config_register_bank_tb_top.sv
// Purpose: Self-checking bench for the configuration register bank.
// Assumes: Short deadline counts; factory current code 4.
// Notes:   Register traffic goes through the host model tasks.
`timescale 1ns/100ps

module pmic_config_register_bank_tb_top;
    localparam int unsigned DL = 20;
    localparam int unsigned HL = 8;
    logic        clk, rst_n, power_on_start, seq_reg1_on, ext_supply_present;
    logic [3:0]  wake;
    logic        reg_wr_en, reg_rd_en, reg_rd_valid, power_ack_pin, power_enable;
    logic        sys_rst_n, reg1_enable, reg1_shunt_enable, chg_enable, chg_eoc_select;
    logic [7:0]  reg_index, reg_wr_data, reg_rd_data, rd;
    logic [4:0]  reg1_voltage_code;
    logic [11:0] reg1_voltage_mv, batt_alarm_mv, batt_irq_mv;
    logic [1:0]  chg_term_select;
    logic [3:0]  chg_cur;
    logic [7:0]  ri [5] = '{8'h00, 8'h01, 8'h04, 8'h07, 8'h02};
    logic [7:0]  re [5] = '{8'h00, 8'h53, 8'h0c, 8'h00, 8'h00};
    logic [7:0]  cw [4] = '{8'h00, 8'ha6, 8'hfd, 8'h47};
    logic [7:0]  cr [4] = '{8'h00, 8'ha6, 8'hbd, 8'h47};
    logic [7:0]  co [4] = '{8'h00, 8'ha6, 8'ha5, 8'h47};
    int          mismatches, samples_checked, n;

    pmic_host_model host (.clk(clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_index(reg_index), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid), .power_ack_pin(power_ack_pin));

    pmic_config_register_bank #(.ACK_DEADLINE_CYCLES(DL), .RESET_HOLD_CYCLES(HL),
        .CUR_FACTORY_DEFAULT(4'h4)) dut (.clk(clk), .rst_n(rst_n),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_index(reg_index),
        .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
        .power_on_start(power_on_start), .seq_reg1_on(seq_reg1_on),
        .wake_battery_insert(wake[3]), .wake_push_button(wake[2]),
        .wake_adapter_supply(wake[1]), .wake_bus_supply(wake[0]),
        .power_ack_pin(power_ack_pin), .ext_supply_present(ext_supply_present),
        .power_enable(power_enable), .system_reset_output_n(sys_rst_n),
        .reg1_enable(reg1_enable), .reg1_shunt_enable(reg1_shunt_enable),
        .reg1_voltage_code(reg1_voltage_code), .reg1_voltage_mv(reg1_voltage_mv),
        .chg_term_select(chg_term_select), .full_rate_charge_current(chg_cur),
        .chg_enable(chg_enable), .chg_eoc_select(chg_eoc_select),
        .batt_alarm_mv(batt_alarm_mv), .batt_irq_mv(batt_irq_mv));

    // Clock, 4 ns period
    initial clk = 1'b0;
    always #2 clk = ~clk;

    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // One-cycle power-up start with wake causes
    task automatic start(input logic [3:0] w, input logic s);
        @(posedge clk) #1;
        power_on_start = 1'b1;
        seq_reg1_on = s;
        wake = w;
        @(posedge clk) #1;
        power_on_start = 1'b0;
        seq_reg1_on = 1'b0;
        wake = 4'h0;
    endtask

    // Hang guard
    initial begin
        #200000;
        mismatches++;
        finish_test();
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        power_on_start = 1'b0;
        seq_reg1_on = 1'b0;
        ext_supply_present = 1'b0;
        wake = 4'h0;
        mismatches = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        check({power_enable, sys_rst_n, reg1_shunt_enable}, 16'h0001);
        check(reg1_voltage_mv, 16'h04b0);
        check(batt_alarm_mv, 16'h0b54);
        check(batt_irq_mv, 16'h0c1c);
        check({chg_term_select, chg_cur, chg_enable, chg_eoc_select}, 16'h0053);
        for (int i = 0; i < 5; i++) begin
            host.rd(ri[i], rd);
            check(rd, re[i]);
        end
        @(posedge clk) #1;
        check(reg_rd_valid, 1'b0);
        $display("test reset values done");
        host.wr(8'h07, 8'hff);
        host.rd(8'h07, rd);
        check(rd, 8'h3f);
        check({reg1_enable, reg1_shunt_enable}, 16'h0002);
        check(reg1_voltage_mv, 16'h0ce4);
        for (int c = 0; c < 22; c++) begin
            host.wr(8'h07, 8'(8'h20 | c));
            check(reg1_voltage_code, 16'(c));
            check(reg1_voltage_mv, 16'(1200 + 100 * c));
        end
        host.wr(8'h07, 8'h0a);
        check({reg1_enable, reg1_shunt_enable}, 16'h0001);
        $display("test regulator done");
        for (int c = 0; c < 32; c++) begin
            host.wr(8'h04, 8'(8'he0 | c));
            check(batt_alarm_mv, 16'(3500 - 50 * (c > 20 ? 20 : c)));
            check(batt_irq_mv, 16'(3700 - 50 * (c > 20 ? 20 : c)));
        end
        host.rd(8'h04, rd);
        check(rd, 8'h1f);
        $display("test battery alarm done");
        for (int i = 0; i < 4; i++) begin
            host.wr(8'h01, cw[i]);
            check({chg_term_select, chg_cur, chg_enable, chg_eoc_select}, co[i]);
            host.rd(8'h01, rd);
            check(rd, cr[i]);
        end
        $display("test charger done");
        host.wr(8'h00, 8'hff);
        host.rd(8'h00, rd);
        check(rd, 8'h10);
        host.wr(8'h00, 8'h00);
        @(posedge clk) #1 wake = 4'hf;
        @(posedge clk) #1 wake = 4'h0;
        host.rd(8'h00, rd);
        check(rd, 8'h0f);
        $display("test event flags done");
        start(4'h4, 1'b1);
        check({power_enable, sys_rst_n, reg1_enable}, 16'h0007);
        n = 0;
        while (sys_rst_n === 1'b1 && n < 60) begin
            @(posedge clk) #1;
            n++;
        end
        check(16'(n), 16'(DL));
        check(power_enable, 1'b1);
        n = 0;
        while (power_enable === 1'b1 && n < 60) begin
            @(posedge clk) #1;
            n++;
        end
        check(16'(n), 16'(HL));
        check(reg1_enable, 1'b0);
        host.rd(8'h00, rd);
        check(rd, 8'h04);
        $display("test deadline done");
        start(4'h0, 1'b0);
        host.wr(8'h00, 8'h10);
        repeat (DL + 5) @(posedge clk);
        #1 check(sys_rst_n, 1'b1);
        ext_supply_present = 1'b1;
        host.wr(8'h00, 8'h00);
        repeat (3) @(posedge clk);
        #1 check(power_enable, 1'b1);
        ext_supply_present = 1'b0;
        repeat (3) @(posedge clk);
        #1 check(power_enable, 1'b0);
        start(4'h0, 1'b0);
        host.pin(1'b1);
        repeat (DL + 5) @(posedge clk);
        #1 check(sys_rst_n, 1'b1);
        host.pin(1'b0);
        repeat (3) @(posedge clk);
        #1 check({power_enable, sys_rst_n}, 16'h0000);
        $display("test acknowledge done");
        finish_test();
    end
endmodule

// ### pmic_host_model.sv
// Purpose: Host model that issues register index/data requests to the bank.
// Assumes: Requests launch 1 ns after a rising clk edge.
// Notes:   Idle index and data lines show the inverse of the last value.
`timescale 1ns/100ps

module pmic_host_model (
    // Clock
    input  wire logic       clk,
    // Register access
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic      [7:0] reg_index,
    output logic      [7:0] reg_wr_data,
    input  wire logic [7:0] reg_rd_data,
    input  wire logic       reg_rd_valid,
    // Acknowledge pin
    output logic            power_ack_pin
);
    // Idle bus at time zero
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_index = 8'h5a;
        reg_wr_data = 8'ha5;
        power_ack_pin = 1'b0;
    end

    // Index and data byte driven together in one write cycle
    task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
        @(posedge clk) #1;
        reg_wr_en = 1'b1;
        reg_index = idx;
        reg_wr_data = dat;
        @(posedge clk) #1;
        reg_wr_en = 1'b0;
        reg_index = ~idx;
        reg_wr_data = ~dat;
    endtask

    // Read; a missing valid pulse returns unknown data
    task automatic rd(input logic [7:0] idx, output logic [7:0] dat);
        int n;
        @(posedge clk) #1;
        reg_rd_en = 1'b1;
        reg_index = idx;
        @(posedge clk) #1;
        reg_rd_en = 1'b0;
        reg_index = ~idx;
        n = 0;
        while (reg_rd_valid !== 1'b1 && n < 4) begin
            @(posedge clk) #1;
            n++;
        end
        dat = (reg_rd_valid === 1'b1) ? reg_rd_data : 8'hxx;
    endtask

    // Acknowledge pin level
    task automatic pin(input logic v);
        power_ack_pin = v;
    endtask
endmodule
